// file: rtl/sfcr_device.sv
// flash device end: continuous main-array read sequencer
`timescale 1ns/1ps
`default_nettype none
module sfcr_device (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // configuration
  input wire logic i_big_page,
  // serial link
  sfcr_link_if.dev link,
  // array write port for preload
  input wire logic i_wr_en,
  input wire logic [sfcr_pkg::ARRAY_AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  // status
  output logic o_busy
);
  import sfcr_pkg::*;

  // main array; the two sram buffers are not modelled and never written
  logic [7:0] mem [ARRAY_BYTES];
  logic cs_q; // previous select level
  logic sck_q; // previous clock level
  logic sck_rise; // sampling edge
  logic sck_fall; // shifting edge
  logic cs_fall; // frame start
  sfcr_dev_state_t state; // sequencer state
  logic [2:0] bit_cnt; // bit within current byte
  logic [1:0] byte_cnt; // byte within address or dummy phase
  logic [1:0] dummy_need; // dummy bytes for this opcode
  logic [7:0] shreg; // incoming byte
  logic [23:0] addr_raw; // received address bytes
  logic [11:0] page; // page counter
  logic [9:0] ofs; // byte within page
  logic [7:0] dout; // byte being shifted out
  logic so_bit; // output bit register
  logic so_en; // output enable register
  logic [7:0] rx_byte; // byte completed on this edge
  logic [ARRAY_AW-1:0] rd_index; // flat array index
  logic [9:0] page_last; // last offset of page
  logic [11:0] start_page; // decoded start page
  logic [9:0] start_ofs; // decoded start offset
  logic was_data; // data phase already seen on the previous edge

  assign sck_rise = ~cs_q & link.sck & ~sck_q;
  assign sck_fall = ~cs_q & ~link.sck & sck_q;
  assign cs_fall = cs_q & ~link.cs_n;
  assign rx_byte = {shreg[6:0], link.si};
  assign page_last = i_big_page ? PAGE_LAST_BIG : PAGE_LAST_STD;
  // flat index uses 528-byte page pitch for either page size
  assign rd_index = ARRAY_AW'(page * 528 + ofs);

  // address decode on last address bit
  always_comb begin
    if (i_big_page) begin
      start_page = addr_raw[OFS_BITS_BIG +: PAGE_BITS];
      start_ofs = addr_raw[9:0];
    end else begin
      start_page = addr_raw[OFS_BITS_STD +: PAGE_BITS];
      start_ofs = {1'b0, addr_raw[8:0]};
    end
  end

  // edge history of the link pins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cs_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cs_q <= link.cs_n;
      sck_q <= link.sck;
    end
  end

  // preload port for the array
  always_ff @(posedge i_clk_sys) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // header sequencer, sampled on rising serial clock
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= SFCR_IDLE;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      dummy_need <= DUMMY_NONE;
      shreg <= 8'h00;
      addr_raw <= 24'h000000;
    end else if (link.cs_n) begin
      state <= SFCR_IDLE;
      bit_cnt <= 3'h0;
    end else if (cs_fall || state == SFCR_IDLE) begin
      state <= SFCR_OPC;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
    end else if (sck_rise) begin
      shreg <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
      unique case (state)
        SFCR_OPC: begin
          if (bit_cnt == BIT_LAST) begin
            state <= SFCR_ADDR;
            byte_cnt <= 2'h0;
            unique case (rx_byte)
              OP_READ_FAST2: dummy_need <= DUMMY_FAST2;
              OP_READ_FAST1: dummy_need <= DUMMY_FAST1;
              OP_READ_SLOW: dummy_need <= DUMMY_NONE;
              OP_READ_LOWPWR: dummy_need <= DUMMY_NONE;
              default: state <= SFCR_IGNORE;
            endcase
          end
        end
        SFCR_ADDR: begin
          addr_raw <= {addr_raw[22:0], link.si};
          if (bit_cnt == BIT_LAST) begin
            byte_cnt <= byte_cnt + 2'h1;
            if (byte_cnt == ADDR_LAST) begin
              byte_cnt <= 2'h0;
              state <= (dummy_need == DUMMY_NONE) ? SFCR_DATA : SFCR_DUMMY;
            end
          end
        end
        SFCR_DUMMY: begin
          // dummy contents are discarded
          if (bit_cnt == BIT_LAST) begin
            byte_cnt <= byte_cnt + 2'h1;
            if (byte_cnt + 2'h1 == dummy_need) begin
              state <= SFCR_DATA;
            end
          end
        end
        SFCR_DATA: state <= SFCR_DATA;
        SFCR_IGNORE: state <= SFCR_IGNORE;
        default: state <= SFCR_IGNORE;
      endcase
    end
  end

  // read address counter with page and array wrap
  // the reload runs one edge into the data phase: without dummies the last
  // address bit lands on the very edge that enters it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      page <= 12'h000;
      ofs <= 10'h000;
      was_data <= 1'b0;
    end else begin
      was_data <= (state == SFCR_DATA);
      if (state != SFCR_DATA || !was_data) begin
        page <= start_page;
        ofs <= start_ofs;
      end else if (sck_fall && bit_cnt == 3'h0) begin
        if (ofs == page_last) begin
          ofs <= 10'h000;
          page <= (page == PAGE_LAST) ? 12'h000 : page + 12'h001;
        end else begin
          ofs <= ofs + 10'h001;
        end
      end
    end
  end

  // output shifter, updates on falling serial clock
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dout <= 8'h00;
      so_bit <= 1'b0;
      so_en <= 1'b0;
    end else if (link.cs_n) begin
      so_en <= 1'b0;
      so_bit <= 1'b0;
    end else if (state == SFCR_DATA && sck_fall) begin
      so_en <= 1'b1;
      if (bit_cnt == 3'h0) begin
        // new byte loads as the previous one ends, no gap at wraps
        so_bit <= mem[rd_index][7];
        dout <= {mem[rd_index][6:0], 1'b0};
      end else begin
        so_bit <= dout[7];
        dout <= {dout[6:0], 1'b0};
      end
    end
  end

  assign link.so_out = so_bit;
  assign link.so_oe = so_en;
  assign o_busy = (state != SFCR_IDLE);
endmodule : sfcr_device
`default_nettype wire

// file: rtl/sfcr_host.sv
// host controller end: issues one continuous read and streams bytes
`timescale 1ns/1ps
`default_nettype none
module sfcr_host (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // serial link
  sfcr_link_if.host link,
  // command request
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [23:0] i_addr,
  input wire logic i_stop,
  // read data stream
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_busy
);
  import sfcr_pkg::*;

  sfcr_host_state_t state; // sequencer state
  logic [3:0] div_cnt; // half period counter
  logic [55:0] hdr; // opcode, address and dummies, msb first
  logic [5:0] hdr_left; // header bits still to send
  logic [2:0] rx_cnt; // bits received in current byte
  logic [7:0] rx_sh; // receive shifter
  logic sck_r; // serial clock register
  logic cs_n_r; // select register
  logic half_tick; // divider expiry
  logic [1:0] dummies; // dummy bytes for requested opcode

  assign half_tick = (div_cnt == SCK_HALF_CYC - 4'h1);
  always_comb begin
    unique case (i_opcode)
      OP_READ_FAST2: dummies = DUMMY_FAST2;
      OP_READ_FAST1: dummies = DUMMY_FAST1;
      default: dummies = DUMMY_NONE;
    endcase
  end

  // serial clock, select and header shifter
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= SFCR_H_IDLE;
      div_cnt <= 4'h0;
      hdr <= 56'h0;
      hdr_left <= 6'h00;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
    end else begin
      unique case (state)
        SFCR_H_IDLE: begin
          sck_r <= 1'b0;
          div_cnt <= 4'h0;
          if (i_start) begin
            cs_n_r <= 1'b0;
            hdr <= {i_opcode, i_addr, 24'h000000};
            hdr_left <= 6'(32 + 8 * dummies);
            state <= SFCR_H_HDR;
          end
        end
        default: begin
          div_cnt <= half_tick ? 4'h0 : div_cnt + 4'h1;
          if (half_tick) begin
            sck_r <= ~sck_r; // mode 0 clock
            // shift on falling, device samples on rising
            if (sck_r && state == SFCR_H_HDR) begin
              hdr <= {hdr[54:0], 1'b0};
              hdr_left <= hdr_left - 6'h01;
              if (hdr_left == 6'h01) begin
                state <= SFCR_H_DATA;
              end
            end
          end
          // stop early in a low phase, never on the edge that raises the
          // clock, so no stray rising edge leaves with the select
          if (i_stop && !sck_r && !half_tick &&
              state == SFCR_H_DATA) begin
            cs_n_r <= 1'b1;
            state <= SFCR_H_IDLE;
          end
        end
      endcase
    end
  end

  // receive shifter, samples on rising serial clock
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_cnt <= 3'h0;
      rx_sh <= 8'h00;
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      o_rd_valid <= 1'b0;
      if (state != SFCR_H_DATA) begin
        rx_cnt <= 3'h0;
      end else if (half_tick && !sck_r) begin
        rx_sh <= {rx_sh[6:0], link.so_out};
        rx_cnt <= rx_cnt + 3'h1;
        if (rx_cnt == BIT_LAST) begin
          o_rd_valid <= 1'b1;
          o_rd_data <= {rx_sh[6:0], link.so_out};
        end
      end
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sck = sck_r;
  assign link.si = hdr[55];
  assign o_busy = (state != SFCR_H_IDLE);
endmodule : sfcr_host
`default_nettype wire

// file: rtl/sfcr_link_if.sv
// serial link between host controller and flash device
`timescale 1ns/1ps
`default_nettype none
interface sfcr_link_if;
  logic cs_n; // chip select, active low, host driven
  logic sck; // serial clock, host driven
  logic si; // host to device data
  logic so_out; // device output value
  logic so_oe; // device output enable, high while driving
  modport dev (input cs_n, input sck, input si, output so_out, output so_oe);
  modport host (output cs_n, output sck, output si, input so_out,
    input so_oe);
endinterface : sfcr_link_if
`default_nettype wire

// file: rtl/sfcr_pkg.sv
// shared constants and types for the serial flash continuous read link
package sfcr_pkg;
  // command opcodes
  localparam logic [7:0] OP_READ_FAST2 = 8'h1B;
  localparam logic [7:0] OP_READ_FAST1 = 8'h0B;
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_READ_LOWPWR = 8'h01;
  // dummy byte counts per opcode
  localparam logic [1:0] DUMMY_FAST2 = 2'h2;
  localparam logic [1:0] DUMMY_FAST1 = 2'h1;
  localparam logic [1:0] DUMMY_NONE = 2'h0;
  // header shape
  localparam int ADDR_BYTES = 3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  // array geometry
  localparam int PAGE_BITS = 12;
  localparam int OFS_BITS_STD = 9;
  localparam int OFS_BITS_BIG = 10;
  localparam logic [9:0] PAGE_LAST_STD = 10'h1FF;
  localparam logic [9:0] PAGE_LAST_BIG = 10'h20F;
  localparam logic [11:0] PAGE_LAST = 12'hFFF;
  localparam int ARRAY_BYTES = 4096 * 528;
  localparam int ARRAY_AW = 22;
  // serial clock divider for the host (half period in system clocks)
  localparam int SCK_HALF_NS = 20;
  localparam int CLK_NS = 10;
  localparam logic [3:0] SCK_HALF_CYC = 4'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
  // device sequencer states
  typedef enum logic [2:0] {
    SFCR_IDLE, SFCR_OPC, SFCR_ADDR, SFCR_DUMMY, SFCR_DATA, SFCR_IGNORE
  } sfcr_dev_state_t;
  // host sequencer states
  typedef enum logic [1:0] {
    SFCR_H_IDLE, SFCR_H_HDR, SFCR_H_DATA
  } sfcr_host_state_t;
endpackage : sfcr_pkg

// file: tb/sfcr_link_sva.sv
// assertion checker watching the serial link between host and device
`timescale 1ns/1ps
`default_nettype none
module sfcr_link_sva (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  // rising serial clocks in the current frame, saturating
  logic [7:0] rises;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // clears while deselected so every frame counts from zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rises <= 8'h00;
    end else if (cs_n) begin
      rises <= 8'h00;
    end else if ($rose(sck) && rises != 8'hFF) begin
      rises <= rises + 8'h01;
    end
  end
  chk_oe_hdr_len: assert property (
    $rose(so_oe) |-> rises inside {8'h20, 8'h28, 8'h30})
    else $error("output driven after wrong header length");
  chk_oe_needs_sel: assert property (
    cs_n [*3] |-> !so_oe)
    else $error("output driven while deselected");
  chk_oe_drop: assert property (
    $rose(cs_n) |-> ##[0:2] !so_oe)
    else $error("output not released after deselect");
  chk_oe_holds: assert property (
    so_oe && !cs_n ##1 !cs_n |-> so_oe)
    else $error("output dropped inside a frame");
  chk_sel_first: assert property (
    $rose(sck) |-> !cs_n && !$past(cs_n))
    else $error("serial clock before select");
  chk_sel_held: assert property (
    $rose(cs_n) |-> rises >= 8'h20)
    else $error("select raised inside the header");
  chk_si_stable: assert property (
    !cs_n && $rose(sck) |-> $stable(si))
    else $error("host data moved at sampling edge");
  chk_so_stable: assert property (
    so_oe && $rose(sck) |-> $stable(so_out))
    else $error("device data moved at sampling edge");
  chk_sck_half: assert property (
    $rose(sck) |-> sck [*2] ##1 !sck)
    else $error("serial clock high phase wrong");
  chk_sck_idle: assert property (
    cs_n [*2] |-> !sck)
    else $error("serial clock moving outside a frame");
  // main header shapes
  cov_two_dummy: cover property ($rose(so_oe) && rises == 8'h30);
  cov_one_dummy: cover property ($rose(so_oe) && rises == 8'h28);
  cov_no_dummy: cover property ($rose(so_oe) && rises == 8'h20);
endmodule : sfcr_link_sva
`default_nettype wire

// file: tb/testbench.sv
// testbench: host and device ends joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfcr_pkg::*;
  // design stimulus and observation
  logic i_clk_sys, i_rst, i_big_page, i_wr_en, i_start, i_stop;
  logic [ARRAY_AW-1:0] i_wr_addr;
  logic [7:0] i_wr_data, i_opcode, o_rd_data;
  logic [23:0] i_addr;
  logic o_rd_valid, o_busy, dev_busy;
  int fail_count = 0;
  int check_count = 0;
  int oe_high; // cycles the device drove during an ignored frame
  sfcr_link_if link ();
  sfcr_device u_sfcr_device (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_big_page(i_big_page), .link(link.dev), .i_wr_en(i_wr_en),
    .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .o_busy(dev_busy));
  sfcr_host u_sfcr_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .link(link.host), .i_start(i_start), .i_opcode(i_opcode),
    .i_addr(i_addr), .i_stop(i_stop), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_busy(o_busy));
  sfcr_link_sva u_sfcr_link_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .so_out(link.so_out), .so_oe(link.so_oe));
  // 100 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // byte stored at an array index; folds page bits in so pages differ
  function automatic logic [7:0] pat(input int idx);
    return 8'(idx) ^ 8'(idx >> 9) ^ 8'h5A;
  endfunction : pat
  // compare and count
  task automatic check(input string what, input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // preload n bytes from page/offset, stream them, then stop
  task automatic run(input logic [7:0] op, input logic big,
      input logic [11:0] pg, input logic [9:0] ofs, input int n);
    logic [11:0] p;
    logic [9:0] o;
    int k;
    int idx[$];
    p = pg;
    o = ofs;
    i_big_page = big;
    for (int b = 0; b < n; b++) begin
      idx.push_back(int'(p) * 528 + int'(o));
      @(negedge i_clk_sys);
      i_wr_en = 1'b1;
      i_wr_addr = ARRAY_AW'(idx[b]);
      i_wr_data = pat(idx[b]);
      // page end moves to the next page; the last page rolls to zero
      if (o == (big ? PAGE_LAST_BIG : PAGE_LAST_STD)) begin
        o = 10'h000;
        p = p + 12'h001;
      end else begin
        o = o + 10'h001;
      end
    end
    @(negedge i_clk_sys);
    i_wr_en = 1'b0;
    i_opcode = op;
    i_addr = big ? {2'h0, pg, ofs} : {3'h0, pg, ofs[8:0]};
    i_start = 1'b1;
    @(negedge i_clk_sys);
    i_start = 1'b0;
    for (int b = 0; b < n; b++) begin
      k = 0;
      while (o_rd_valid !== 1'b1 && k < 3000) begin
        @(negedge i_clk_sys);
        k++;
      end
      check("byte valid", {7'h0, o_rd_valid}, 8'h01);
      check("byte data", o_rd_data, pat(idx[b]));
      @(negedge i_clk_sys);
    end
    // stop is a level; host ends the frame at the next low phase
    i_stop = 1'b1;
    k = 0;
    while (o_busy !== 1'b0 && k < 300) begin
      @(negedge i_clk_sys);
      k++;
    end
    i_stop = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    check("select", {7'h0, link.cs_n}, 8'h01);
    check("output enable", {7'h0, link.so_oe}, 8'h00);
    check("device busy", {7'h0, dev_busy}, 8'h00);
    $display("test opcode %h done", op);
  endtask : run
  // main sequence
  initial begin
    i_rst = 1'b1;
    i_big_page = 1'b0;
    i_wr_en = 1'b0;
    i_wr_addr = '0;
    i_wr_data = 8'h00;
    i_start = 1'b0;
    i_stop = 1'b0;
    i_opcode = 8'h00;
    i_addr = 24'h000000;
    repeat (16) @(negedge i_clk_sys);
    i_rst = 1'b0;
    run(OP_READ_SLOW, 1'b0, 12'h005, 10'h1FE, 4);
    run(OP_READ_FAST2, 1'b1, PAGE_LAST, 10'h20E, 4);
    run(OP_READ_FAST1, 1'b0, PAGE_LAST, 10'h1FF, 2);
    run(OP_READ_LOWPWR, 1'b1, 12'h123, 10'h20F, 3);
    // unknown opcode: the device ignores the frame and never drives
    i_opcode = 8'h00;
    i_start = 1'b1;
    @(negedge i_clk_sys);
    i_start = 1'b0;
    oe_high = 0;
    repeat (400) begin
      @(negedge i_clk_sys);
      if (link.so_oe !== 1'b0) begin
        oe_high++;
      end
    end
    check("ignored enable", {7'h0, oe_high != 0}, 8'h00);
    i_stop = 1'b1;
    repeat (8) @(negedge i_clk_sys);
    i_stop = 1'b0;
    check("ignored select", {7'h0, link.cs_n}, 8'h01);
    check("ignored busy", {7'h0, dev_busy}, 8'h00);
    $display("test ignored opcode done");
    stop_test();
  end
  // watchdog: four short reads and the ignored frame need under two thousand cycles
  initial begin
    repeat (30000) @(posedge i_clk_sys);
    fail_count++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
